// file: hw/uisl_top.sv
// Purpose: serial port with transmit/receive interrupt pulses and receive error status
// Assumes: 125 MHz aclk, synchronous active-low reset, AXI4-Lite register access
// Notes: one bit period is sixteen divider reloads
module uisl_top import uisl_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd,
  output logic txd,
  output logic tx_irq,
  output logic rx_irq
);
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [8:0] wdata_r;
  logic wstrb_r;
  logic wr_go;
  logic wr_ok;
  logic rd_go;
  logic rd_ok;
  logic [7:0] rd_val;
  logic rd_rx;
  logic rd_st;
  uisl_ctl_t ctl_r;
  logic divider_timer_enable;
  logic [7:0] div_hi_r;
  logic [7:0] div_lo_r;
  logic [7:0] node_r;
  logic [15:0] bit_rate_divider;
  logic [15:0] cnt_r;
  logic tick;
  logic uart_on;
  logic timer_evt;
  logic [8:0] thr_r;
  logic thr_full_r;
  logic tx_holding_empty;
  logic tx_set;
  logic tx_start;
  uisl_tx_t tx_st_r;
  logic [10:0] tx_sh_r;
  logic [3:0] tx_os_r;
  logic [3:0] tx_bit_r;
  logic [3:0] tx_last_r;
  logic rxs;
  uisl_rx_t rx_st_r;
  logic [3:0] rx_os_r;
  logic [3:0] rx_bit_r;
  logic [8:0] rx_sh_r;
  logic rx_done;
  logic rx_fe;
  logic rx_brk;
  logic rx_isaddr;
  logic [7:0] rx_byte;
  logic [7:0] rx_data_r;
  logic rx_byte_available;
  logic ovr_r;
  logic line_break_seen;
  logic fe_r;
  logic ovr_pend_r;
  logic brk_pend_r;
  logic st_seen_r;
  logic addr_hit_r;
  logic rd_norm;
  logic rx_room;
  logic data_evt;
  logic err_evt;

  // register bus: write address and data taken in either order
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_hold_r && w_hold_r;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wr_ok = awaddr_r inside {A_TXD, A_CTL0, A_CTL1, A_DIVH, A_DIVL, A_NODE};
  assign rd_ok = s_axi_araddr inside {A_RXD, A_STAT, A_CTL0, A_CTL1, A_DIVH, A_DIVL, A_NODE};
  assign rd_rx = rd_go && s_axi_araddr == A_RXD;
  assign rd_st = rd_go && s_axi_araddr == A_STAT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 9'h000;
      wstrb_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata[8:0];
        wstrb_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_val = 8'h00;
    case (s_axi_araddr)
      A_RXD: rd_val = rx_data_r;
      A_STAT: rd_val = {2'b00, tx_st_r == TX_IDLE && thr_full_r == 1'b0, tx_holding_empty,
                        fe_r, line_break_seen, ovr_r, rx_byte_available};
      A_CTL0: rd_val = {2'b00, ctl_r};
      A_CTL1: rd_val = {7'h00, divider_timer_enable};
      A_DIVH: rd_val = div_hi_r;
      A_DIVL: rd_val = div_lo_r;
      A_NODE: rd_val = node_r;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OK;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_val};
      s_axi_rresp <= rd_ok ? RESP_OK : RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r <= CTL_RST;
      divider_timer_enable <= 1'b0;
      div_hi_r <= DIV_RST[15:8];
      div_lo_r <= DIV_RST[7:0];
      node_r <= 8'h00;
    end else if (wr_go && wstrb_r) begin
      case (awaddr_r)
        A_CTL0: ctl_r <= wdata_r[5:0];
        A_CTL1: divider_timer_enable <= wdata_r[C_BRGIE];
        A_DIVH: div_hi_r <= wdata_r[7:0];
        A_DIVL: div_lo_r <= wdata_r[7:0];
        A_NODE: node_r <= wdata_r[7:0];
        default: ;
      endcase
    end
  end

  // divider: reload every divisor clocks, sixteen reloads per bit
  assign bit_rate_divider = {div_hi_r, div_lo_r};
  assign uart_on = ctl_r.rxen || ctl_r.txen;
  assign tick = cnt_r <= 16'h0001;
  assign timer_evt = tick && !uart_on && divider_timer_enable;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= DIV_RST;
    end else if (!uart_on && !divider_timer_enable) begin
      cnt_r <= bit_rate_divider;
    end else if (tick) begin
      cnt_r <= bit_rate_divider;
    end else begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  // transmitter
  assign tx_start = tx_st_r == TX_IDLE && thr_full_r && ctl_r.txen && tick;
  assign tx_set = tx_st_r == TX_SHIFT && tick && tx_os_r == OVS_LAST && tx_bit_r == 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thr_r <= 9'h000;
      thr_full_r <= 1'b0;
      tx_holding_empty <= 1'b1;
    end else begin
      if (wr_go && wstrb_r && awaddr_r == A_TXD) begin
        thr_r <= wdata_r;
        thr_full_r <= 1'b1;
        tx_holding_empty <= 1'b0;
      end else if (tx_start) begin
        thr_full_r <= 1'b0;
      end
      if (tx_set && !thr_full_r) begin
        tx_holding_empty <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 11'h7ff;
      tx_os_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_last_r <= NBITS_STD;
      txd <= 1'b1;
    end else begin
      txd <= tx_sh_r[0];
      case (tx_st_r)
        TX_IDLE: begin
          tx_sh_r <= 11'h7ff;
          if (tx_start) begin
            tx_sh_r <= {1'b1, ctl_r.mp ? thr_r[T_ADDR] : 1'b1, thr_r[7:0], 1'b0};
            tx_last_r <= ctl_r.mp ? NBITS_MP : NBITS_STD;
            tx_os_r <= 4'h0;
            tx_bit_r <= 4'h0;
            tx_st_r <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tick) begin
            tx_os_r <= tx_os_r + 4'h1;
            if (tx_os_r == OVS_LAST) begin
              tx_sh_r <= {1'b1, tx_sh_r[10:1]};
              tx_bit_r <= tx_bit_r + 4'h1;
              if (tx_bit_r == tx_last_r) begin
                tx_st_r <= TX_IDLE;
              end
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  // receiver
  uisl_sync3 uisl_sync3_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(rxd),
    .dout(rxs)
  );

  assign rx_done = rx_st_r == RX_RUN && tick && rx_os_r == OVS_MID && rx_bit_r == tx_last_rx(ctl_r.mp);
  assign rx_fe = !rxs;
  assign rx_byte = ctl_r.mp ? rx_sh_r[7:0] : rx_sh_r[8:1];
  assign rx_isaddr = ctl_r.mp && rx_sh_r[8];
  assign rx_brk = rx_fe && rx_byte == 8'h00 && !rx_isaddr;

  function automatic logic [3:0] tx_last_rx(input logic mp);
    tx_last_rx = mp ? NBITS_MP : NBITS_STD;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_r <= RX_IDLE;
      rx_os_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 9'h000;
    end else begin
      case (rx_st_r)
        RX_IDLE: begin
          if (!rxs && ctl_r.rxen) begin
            rx_os_r <= 4'h0;
            rx_bit_r <= 4'h0;
            rx_st_r <= RX_RUN;
          end
        end
        RX_RUN: begin
          if (tick) begin
            rx_os_r <= rx_os_r + 4'h1;
            if (rx_os_r == OVS_MID) begin
              rx_bit_r <= rx_bit_r + 4'h1;
              if (rx_bit_r == 4'h0 && rxs) begin
                rx_st_r <= RX_IDLE;
              end else if (rx_done) begin
                rx_st_r <= RX_IDLE;
              end else if (rx_bit_r != 4'h0) begin
                rx_sh_r <= {rxs, rx_sh_r[8:1]};
              end
            end
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // receive data and error flags
  assign rd_norm = rd_rx && !ovr_pend_r && !ovr_r;
  assign rx_room = !rx_byte_available || rd_norm;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data_r <= 8'h00;
      rx_byte_available <= 1'b0;
      ovr_r <= 1'b0;
      line_break_seen <= 1'b0;
      fe_r <= 1'b0;
      ovr_pend_r <= 1'b0;
      brk_pend_r <= 1'b0;
      st_seen_r <= 1'b0;
      addr_hit_r <= 1'b0;
    end else begin
      if (rd_st && ovr_r) begin
        st_seen_r <= 1'b1;
      end
      if (rd_rx && ovr_pend_r) begin
        ovr_r <= 1'b1;
        line_break_seen <= brk_pend_r;
        ovr_pend_r <= 1'b0;
        rx_byte_available <= 1'b1;
      end else if (rd_rx && ovr_r && st_seen_r) begin
        ovr_r <= 1'b0;
        line_break_seen <= 1'b0;
        fe_r <= 1'b0;
        st_seen_r <= 1'b0;
        rx_byte_available <= 1'b0;
      end else if (rd_norm) begin
        rx_byte_available <= 1'b0;
        line_break_seen <= 1'b0;
        fe_r <= 1'b0;
      end
      if (rx_done) begin
        if (rx_room) begin
          rx_data_r <= rx_byte;
          rx_byte_available <= 1'b1;
          fe_r <= rx_fe;
          line_break_seen <= rx_brk;
          if (rx_isaddr) begin
            addr_hit_r <= rx_byte == node_r;
          end
        end else begin
          ovr_pend_r <= 1'b1;
          brk_pend_r <= rx_brk;
        end
      end
    end
  end

  assign data_evt = rx_done && rx_room && ctl_r.rdaie && (!ctl_r.mp || rx_isaddr || addr_hit_r);
  assign err_evt = rx_done && ctl_r.errie && (rx_fe || rx_brk || !rx_room);

  // interrupt pulses, one clock each, except timer pulses at divisor 0 or 1, which hold rx_irq high every clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      tx_irq <= tx_set && !thr_full_r && !tx_holding_empty && ctl_r.txie;
      rx_irq <= data_evt || err_evt || timer_evt;
    end
  end
endmodule

// file: hw/uisl_pkg.sv
// Purpose: shared constants and types of the serial port interrupt/status block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: only the low byte of each register is used, plus bit 8 (T_ADDR) of the transmit register
package uisl_pkg;
  localparam logic [7:0] A_TXD = 8'h00;
  localparam logic [7:0] A_RXD = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_CTL0 = 8'h0c;
  localparam logic [7:0] A_CTL1 = 8'h10;
  localparam logic [7:0] A_DIVH = 8'h14;
  localparam logic [7:0] A_DIVL = 8'h18;
  localparam logic [7:0] A_NODE = 8'h1c;
  // status bit positions
  localparam int S_RDA = 0;
  localparam int S_OVR = 1;
  localparam int S_BRK = 2;
  localparam int S_FE = 3;
  localparam int S_THE = 4;
  localparam int S_TIDLE = 5;
  // control 0 bit positions
  localparam int C_RXEN = 0;
  localparam int C_TXEN = 1;
  localparam int C_MP = 2;
  localparam int C_RDAIE = 3;
  localparam int C_ERRIE = 4;
  localparam int C_TXIE = 5;
  // control 1 bit positions
  localparam int C_BRGIE = 0;
  // transmit write data bit carrying the multidrop address flag
  localparam int T_ADDR = 8;
  localparam logic [15:0] DIV_RST = 16'h0001;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] NBITS_STD = 4'h9;
  localparam logic [3:0] NBITS_MP = 4'ha;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  typedef struct packed {
    logic txie;
    logic errie;
    logic rdaie;
    logic mp;
    logic txen;
    logic rxen;
  } uisl_ctl_t;
  localparam uisl_ctl_t CTL_RST = 6'h00;
  typedef enum {TX_IDLE, TX_SHIFT} uisl_tx_t;
  typedef enum {RX_IDLE, RX_RUN} uisl_rx_t;
endpackage

// file: hw/uisl_sync3.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input idles high
// Notes: output changes once stages two and three agree
module uisl_sync3 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule

// file: test/uisl_monitor.sv
// Purpose: port-level checks of the serial interrupt block
// Assumes: one aclk domain, aresetn synchronous active low
// Notes: bound to uisl_top below
module uisl_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  tx_pulse_a: assert property (tx_irq |=> !tx_irq)
    else $error("tx_irq held over one cycle");
  rx_pulse_a: assert property (rx_irq |=> !rx_irq)
    else $error("rx_irq held over one cycle");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  rdata_top_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
endmodule

bind uisl_top uisl_monitor uisl_monitor_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .tx_irq(tx_irq), .rx_irq(rx_irq));

// file: test/uisl_line_model.sv
// Purpose: far-side serial device: sends frames on rxd, decodes txd
// Assumes: divisor 1, so one bit is 16 aclk cycles
// Notes: line idles high
module uisl_line_model (
  input wire logic aclk,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got = 8'h00;
  initial rxd = 1'b1;
  task automatic send(input logic [8:0] d, input int n, input logic stop);
    rxd <= 1'b0;
    repeat (16) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (16) @(posedge aclk);
    end
    rxd <= stop;
    repeat (16) @(posedge aclk);
    rxd <= 1'b1;
    repeat (16) @(posedge aclk);
  endtask
  // sample each of the eight data bits in its middle
  always begin
    @(negedge txd);
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge aclk);
      got[i] = txd;
    end
    repeat (16) @(posedge aclk);
  end
endmodule

// file: test/uisl_top_bench.sv
// Purpose: self-checking bench of the serial interrupt block
// Assumes: divisor left at reset value outside the timer test
// Notes: registers reached over AXI4-Lite tasks
module uisl_top_bench import uisl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, txd, rxd, tx_irq, rx_irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  int miscompares = 0;
  int checked = 0;
  int ntx = 0;
  int nrx = 0;
  uisl_top uisl_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rxd(rxd), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq));
  uisl_line_model uisl_line_model_i (.aclk(aclk), .txd(txd), .rxd(rxd));
  initial forever #4 aclk = ~aclk;
  // count pulses mid-cycle so a scenario's snapshot never races the count
  always @(negedge aclk) begin
    if (tx_irq === 1'b1) ntx++;
    if (rx_irq === 1'b1) nrx++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // lag delays the response ready by that many cycles, so the slave must hold its answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int lag = 0);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (lag > 0) begin
        lag--;
        if (lag == 0) bready <= 1'b1;
      end
    end while (bvalid !== 1'b1 || bready !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a, input int lag = 0);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (lag > 0) begin
        lag--;
        if (lag == 0) rready <= 1'b1;
      end
    end while (rvalid !== 1'b1 || rready !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    r = rresp;
  endtask
  task automatic t_regs;
    rd(A_CTL0);
    chk(v, 32'h0);
    rd(A_DIVL, 3);
    chk(v, 32'h1);
    rd(8'h20);
    chk(v, 32'h0);
    chk(r, RESP_ERR);
    wr(A_STAT, 32'h1, 3);
    chk(r, RESP_ERR);
    wr(A_NODE, 32'h5a, 2);
    chk(r, RESP_OK);
    rd(A_NODE);
    chk(v, 32'h5a);
  endtask
  task automatic t_tx;
    int b;
    wr(A_CTL0, 32'h22);
    b = ntx;
    wr(A_TXD, 32'h5a);
    rd(A_STAT);
    chk(v[5:4], 2'b00);
    repeat (24) @(posedge aclk);
    rd(A_STAT);
    chk(v[5:4], 2'b01);
    repeat (180) @(posedge aclk);
    chk(uisl_line_model_i.got, 8'h5a);
    chk(ntx - b, 1);
  endtask
  task automatic t_rx;
    int b;
    wr(A_CTL0, 32'h19);
    b = nrx;
    uisl_line_model_i.send(9'h0a5, 8, 1'b1);
    chk(nrx - b, 1);
    rd(A_RXD);
    chk(v, 32'ha5);
    rd(A_STAT);
    chk(v[3:0], 4'h0);
  endtask
  task automatic t_ovr;
    int b;
    b = nrx;
    uisl_line_model_i.send(9'h011, 8, 1'b1);
    uisl_line_model_i.send(9'h022, 8, 1'b1);
    chk(nrx - b, 2);
    rd(A_STAT);
    chk(v[3:0], 4'h1);
    rd(A_RXD);
    chk(v, 32'h11);
    rd(A_STAT);
    chk(v[3:0], 4'h3);
    rd(A_RXD);
    rd(A_STAT);
    chk(v[3:0], 4'h0);
  endtask
  task automatic t_err;
    int b;
    for (int i = 0; i < 2; i++) begin
      b = nrx;
      uisl_line_model_i.send(i ? 9'h000 : 9'h00f, 8, 1'b0);
      chk(nrx - b, 1);
      rd(A_STAT);
      chk(v[3 - i], 1'b1);
      rd(A_RXD);
      rd(A_STAT);
      chk(v[3:0], 4'h0);
    end
  endtask
  task automatic t_mp;
    logic [8:0] f[4] = '{9'h144, 9'h055, 9'h133, 9'h066};
    int e[4] = '{1, 1, 2, 3};
    int b;
    wr(A_NODE, 32'h33);
    wr(A_CTL0, 32'h0d);
    b = nrx;
    for (int i = 0; i < 4; i++) begin
      uisl_line_model_i.send(f[i], 9, 1'b1);
      rd(A_RXD);
      chk(nrx - b, e[i]);
    end
    chk(v, 32'h66);
  endtask
  task automatic t_timer;
    int n;
    int b;
    wr(A_CTL0, 32'h0);
    wr(A_DIVL, 32'h5);
    wr(A_CTL1, 32'h1);
    do @(posedge aclk); while (rx_irq !== 1'b1);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (rx_irq !== 1'b1);
    chk(n, 5);
    wr(A_CTL0, 32'h1);
    b = nrx;
    repeat (40) @(posedge aclk);
    chk(nrx - b, 0);
  endtask
  task automatic wrap_up;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_tx;
    t_rx;
    t_ovr;
    t_err;
    t_mp;
    t_timer;
    wrap_up;
  end
endmodule
